// >>> port_ab_data_registers.v
// Design decision made here: strobed register access.
`timescale 1ns/1ns
`include "port_ab_defs.vh"
// Overview of operation
// - read returns stored bit when direction is output, else synchronised pin.
// - in general purpose output mode the stored bit drives the pin.
// - enabled lcd segment takes pin from general purpose use on every bit of both ports.
// - first port bit 3: lcd first, then periodic clock, then general purpose.
// - first port bit 3: enabled periodic clock overrides general purpose use.
// - first port bit 1: lcd, then nonmaskable interrupt input, then general purpose.
// - first port bit 0: lcd, then maskable interrupt input, then general purpose.
// - with no alternative function active, pin is general purpose input or output.
// - first port data register at 0x0000, read and write anytime.
// - second port data register at 0x0001, read and write anytime.
// - both data registers reset to zero.
// - direction 1 is output, 0 input; lcd segment disables both buffers.
// - reads may lag a direction change by up to two clocks.
module port_ab_data_registers (
   input  wire        clock,
   input  wire        arst_n,
   // register port
   input  wire [15:0] addr,
   input  wire [7:0]  wdata,
   input  wire        wr_stb,
   input  wire        rd_stb,
   output reg  [7:0]  rdata,
   // pins of the first port
   input  wire [7:0]  first_port_pin_in,
   output reg  [7:0]  first_port_pin_out,
   output reg  [7:0]  first_port_pin_oe,
   output reg  [7:0]  first_port_in_buf_en,
   // pins of the second port
   input  wire [7:0]  second_port_pin_in,
   output reg  [7:0]  second_port_pin_out,
   output reg  [7:0]  second_port_pin_oe,
   output reg  [7:0]  second_port_in_buf_en,
   // alternative function controls
   input  wire [7:0]  first_port_lcd_en,
   input  wire [7:0]  second_port_lcd_en,
   input  wire        periodic_clock_en,
   input  wire        periodic_clock_output,
   input  wire        nonmaskable_irq_en,
   input  wire        maskable_irq_en,
   // interrupt inputs toward interrupt logic
   output reg         nonmaskable_interrupt_input,
   output reg         maskable_interrupt_input
);
   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   reg  [7:0] first_port_data_reg;
   reg  [7:0] second_port_data_reg;
   reg  [7:0] first_port_direction;
   reg  [7:0] second_port_direction;
   wire [7:0] first_port_sync;
   wire [7:0] second_port_sync;
   reg  [7:0] first_dir_eff;
   reg  [7:0] second_dir_eff;
   reg  [7:0] first_port_read_alias;
   reg  [7:0] second_port_read_alias;
   reg  [7:0] rdata_nxt;

   // data source per bit: stored data for outputs, pin for inputs
   function [7:0] read_mux;
      input [7:0] dir;
      input [7:0] stored;
      input [7:0] pin;
      begin
         read_mux = (dir & stored) | (~dir & pin);
      end
   endfunction

   // ---------------------------------------------------------------
   // pin input synchronisers
   // ---------------------------------------------------------------
   pin_sync #(
      .WIDTH    (8)
   ) u_sync_first (
      .clock    (clock),
      .arst_n   (arst_n),
      .async_in (first_port_pin_in),
      .sync_out (first_port_sync)
   );

   pin_sync #(
      .WIDTH    (8)
   ) u_sync_second (
      .clock    (clock),
      .arst_n   (arst_n),
      .async_in (second_port_pin_in),
      .sync_out (second_port_sync)
   );

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   // writes land regardless of pin ownership
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         first_port_data_reg   <= `PORT_DATA_RESET;
         second_port_data_reg  <= `PORT_DATA_RESET;
         first_port_direction  <= `PORT_DIR_RESET;
         second_port_direction <= `PORT_DIR_RESET;
      end else if (wr_stb) begin
         if (addr == `FIRST_PORT_DATA_ADDR) begin
            first_port_data_reg <= wdata;
         end else if (addr == `SECOND_PORT_DATA_ADDR) begin
            second_port_data_reg <= wdata;
         end else if (addr == `FIRST_PORT_DIR_ADDR) begin
            first_port_direction <= wdata;
         end else if (addr == `SECOND_PORT_DIR_ADDR) begin
            second_port_direction <= wdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // pin ownership
   // ---------------------------------------------------------------
   // priority: lcd, then dedicated function, then general purpose
   always @* begin
      first_dir_eff  = first_port_direction;
      second_dir_eff = second_port_direction;
      first_port_pin_out    = first_port_data_reg;
      first_port_pin_oe     = first_port_direction;
      first_port_in_buf_en  = ~first_port_direction;
      second_port_pin_out   = second_port_data_reg;
      second_port_pin_oe    = second_port_direction;
      second_port_in_buf_en = ~second_port_direction;
      // periodic clock forces bit 3 to output
      if (periodic_clock_en) begin
         first_port_pin_out[`BIT_PERIODIC_CLOCK]   = periodic_clock_output;
         first_port_pin_oe[`BIT_PERIODIC_CLOCK]    = 1'b1;
         first_port_in_buf_en[`BIT_PERIODIC_CLOCK] = 1'b0;
         first_dir_eff[`BIT_PERIODIC_CLOCK]        = 1'b1;
      end
      // interrupt inputs force their pins to input
      if (nonmaskable_irq_en) begin
         first_port_pin_oe[`BIT_NONMASKABLE_IRQ]    = 1'b0;
         first_port_in_buf_en[`BIT_NONMASKABLE_IRQ] = 1'b1;
         first_dir_eff[`BIT_NONMASKABLE_IRQ]        = 1'b0;
      end
      if (maskable_irq_en) begin
         first_port_pin_oe[`BIT_MASKABLE_IRQ]    = 1'b0;
         first_port_in_buf_en[`BIT_MASKABLE_IRQ] = 1'b1;
         first_dir_eff[`BIT_MASKABLE_IRQ]        = 1'b0;
      end
      // lcd segment wins over everything and disables both buffers
      first_port_pin_oe     = first_port_pin_oe & ~first_port_lcd_en;
      first_port_in_buf_en  = first_port_in_buf_en & ~first_port_lcd_en;
      first_port_pin_out    = first_port_pin_out & ~first_port_lcd_en;
      second_port_pin_oe    = second_port_pin_oe & ~second_port_lcd_en;
      second_port_in_buf_en = second_port_in_buf_en & ~second_port_lcd_en;
      second_port_pin_out   = second_port_pin_out & ~second_port_lcd_en;
   end

   // interrupt inputs, gated by ownership so lcd use blocks them
   always @* begin
      nonmaskable_interrupt_input = nonmaskable_irq_en & ~first_port_lcd_en[`BIT_NONMASKABLE_IRQ]
                                    & first_port_sync[`BIT_NONMASKABLE_IRQ];
      maskable_interrupt_input    = maskable_irq_en & ~first_port_lcd_en[`BIT_MASKABLE_IRQ]
                                    & first_port_sync[`BIT_MASKABLE_IRQ];
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   // pin values pass two synchroniser stages, hence the settle delay
   always @* begin
      first_port_read_alias  = read_mux(first_dir_eff, first_port_data_reg, first_port_sync);
      second_port_read_alias = read_mux(second_dir_eff, second_port_data_reg, second_port_sync);
      rdata_nxt = `UNMAPPED_READ;
      if (addr == `FIRST_PORT_DATA_ADDR) begin
         rdata_nxt = first_port_read_alias;
      end else if (addr == `SECOND_PORT_DATA_ADDR) begin
         rdata_nxt = second_port_read_alias;
      end else if (addr == `FIRST_PORT_DIR_ADDR) begin
         rdata_nxt = first_port_direction;
      end else if (addr == `SECOND_PORT_DIR_ADDR) begin
         rdata_nxt = second_port_direction;
      end
   end

   // read data valid only in the cycle after the strobe
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 8'h00;
      end else if (rd_stb) begin
         rdata <= rdata_nxt;
      end else begin
         rdata <= 8'h00;
      end
   end
endmodule // port_ab_data_registers

// >>> port_ab_defs.vh
`ifndef PORT_AB_DEFS_VH
`define PORT_AB_DEFS_VH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define FIRST_PORT_DATA_ADDR   16'h0000
`define SECOND_PORT_DATA_ADDR  16'h0001
`define FIRST_PORT_DIR_ADDR    16'h0002
`define SECOND_PORT_DIR_ADDR   16'h0003
// ---------------------------------------------------------------
// reset values and field positions
// ---------------------------------------------------------------
`define PORT_DATA_RESET        8'h00
`define PORT_DIR_RESET         8'h00
`define UNMAPPED_READ          8'h00
`define BIT_MASKABLE_IRQ       0
`define BIT_NONMASKABLE_IRQ    1
`define BIT_PERIODIC_CLOCK     3
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define READ_SETTLE_CYCLES     2
`endif

// >>> pin_sync.v
`timescale 1ns/1ns
// two-stage synchroniser for a bank of pin inputs
module pin_sync #(
   parameter WIDTH = 8
) (
   input  wire             clock,
   input  wire             arst_n,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_r;

   // first stage feeds only the second stage
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         meta_r   <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule // pin_sync

// >>> pin_world.sv
`timescale 1ns/1ns
// pins of one port: driven bits follow the device, released bits take the outside level
module pin_world (
   input  wire [7:0] pin_out,
   input  wire [7:0] pin_oe,
   input  wire [7:0] outside,
   output wire [7:0] pin_in
);
   // per-bit wire resolution
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & outside);
endmodule // pin_world

// >>> port_ab_chk_sva.sv
`timescale 1ns/1ns
module port_ab_chk (
   input wire       clock,
   input wire       arst_n,
   input wire       rd_stb,
   input wire [7:0] rdata,
   input wire [7:0] first_port_pin_out,
   input wire [7:0] first_port_pin_oe,
   input wire [7:0] first_port_in_buf_en,
   input wire [7:0] second_port_pin_out,
   input wire [7:0] second_port_pin_oe,
   input wire [7:0] second_port_in_buf_en,
   input wire [7:0] first_port_lcd_en,
   input wire [7:0] second_port_lcd_en,
   input wire       periodic_clock_en,
   input wire       periodic_clock_output,
   input wire       nonmaskable_irq_en,
   input wire       maskable_irq_en,
   input wire       nonmaskable_interrupt_input,
   input wire       maskable_interrupt_input
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // ---------------------------------------------------------------
   // pin ownership and read data
   // ---------------------------------------------------------------
   AST_A_LCD_OFF: assert property (((first_port_pin_oe | first_port_in_buf_en | first_port_pin_out)
      & first_port_lcd_en) == 8'h00) else $error("first port lcd bit not released");
   AST_B_LCD_OFF: assert property (((second_port_pin_oe | second_port_in_buf_en) & second_port_lcd_en) == 8'h00)
      else $error("second port lcd bit not released");
   AST_CLK_OWNS: assert property (periodic_clock_en && !first_port_lcd_en[3] |-> first_port_pin_oe[3]
      && first_port_pin_out[3] == periodic_clock_output) else $error("clock output not on bit 3");
   AST_LCD_OVER_CLK: assert property (periodic_clock_en && first_port_lcd_en[3] |-> !first_port_pin_oe[3])
      else $error("clock output drove an lcd pin");
   AST_NMI_IN: assert property (nonmaskable_irq_en && !first_port_lcd_en[1] |-> !first_port_pin_oe[1]
      && first_port_in_buf_en[1]) else $error("bit 1 not an input");
   AST_IRQ_IN: assert property (maskable_irq_en && !first_port_lcd_en[0] |-> !first_port_pin_oe[0]
      && first_port_in_buf_en[0]) else $error("bit 0 not an input");
   AST_LCD_GATES_IRQ: assert property (first_port_lcd_en[1:0] != 2'b00 |-> !(first_port_lcd_en[1]
      && nonmaskable_interrupt_input) && !(first_port_lcd_en[0] && maskable_interrupt_input))
      else $error("interrupt seen through lcd pin");
   AST_RDATA_ONE: assert property (!rd_stb |=> rdata == 8'h00) else $error("read data outside its cycle");
endmodule // port_ab_chk

bind port_ab_data_registers port_ab_chk u_chk (.clock, .arst_n, .rd_stb, .rdata, .first_port_pin_out,
   .first_port_pin_oe, .first_port_in_buf_en, .second_port_pin_out, .second_port_pin_oe, .second_port_in_buf_en,
   .first_port_lcd_en, .second_port_lcd_en, .periodic_clock_en, .periodic_clock_output, .nonmaskable_irq_en,
   .maskable_irq_en, .nonmaskable_interrupt_input, .maskable_interrupt_input);

// >>> tb.sv
`timescale 1ns/1ns
module tb;
   reg         clock, arst_n, wr_stb, rd_stb;
   reg  [15:0] addr;
   reg  [7:0]  wdata, lcd_a, lcd_b, ext_a, ext_b, got;
   reg  [3:0]  en; // clock enable, nmi enable, irq enable, clock level
   reg  [35:0] rows [0:5]; // direction, data, lcd, enables, outside level
   wire [7:0]  rdata, pin_a, out_a, oe_a, pin_b, out_b, oe_b, ib_a, ib_b;
   wire        nmi_o, irq_o;
   integer     errors = 0, samples_checked = 0, i;
   port_ab_data_registers dut (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .first_port_pin_in(pin_a), .first_port_pin_out(out_a),
      .first_port_pin_oe(oe_a), .first_port_in_buf_en(ib_a), .second_port_pin_in(pin_b), .second_port_pin_out(out_b),
      .second_port_pin_oe(oe_b), .second_port_in_buf_en(ib_b), .first_port_lcd_en(lcd_a), .second_port_lcd_en(lcd_b),
      .periodic_clock_en(en[3]), .periodic_clock_output(en[0]), .nonmaskable_irq_en(en[2]),
      .maskable_irq_en(en[1]), .nonmaskable_interrupt_input(nmi_o), .maskable_interrupt_input(irq_o));
   pin_world pa (.pin_out(out_a), .pin_oe(oe_a), .outside(ext_a), .pin_in(pin_a));
   pin_world pb (.pin_out(out_b), .pin_oe(oe_b), .outside(ext_b), .pin_in(pin_b));
   // clock and watchdog
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      #200000 errors = errors + 1;
      close_out;
   end
   task close_out;
      begin
         $display("checked %0d mismatches %0d", samples_checked, errors);
         if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task cmp(input [63:0] nm, input [7:0] exp, input [7:0] seen);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // register bus cycles
   task wr(input [15:0] a, input [7:0] d);
      begin
         @(posedge clock);
         addr <= a;
         wdata <= d;
         wr_stb <= 1'b1;
         @(posedge clock);
         wr_stb <= 1'b0;
      end
   endtask
   task rd(input [15:0] a);
      begin
         @(posedge clock);
         addr <= a;
         rd_stb <= 1'b1;
         @(posedge clock);
         rd_stb <= 1'b0;
         #1 got = rdata;
      end
   endtask
   // pins and reads of both ports against the ownership order
   task check_ports(input [7:0] dr, input [7:0] d);
      reg [7:0] eo, ev, ed;
      begin
         eo = dr & ~lcd_a;
         ev = d;
         ed = dr;
         if (en[3]) {eo[3], ev[3], ed[3]} = {!lcd_a[3], en[0], 1'b1};
         if (en[2]) {eo[1], ed[1]} = 2'b00;
         if (en[1]) {eo[0], ed[0]} = 2'b00;
         cmp("oe_a", eo, oe_a);
         cmp("out_a", ev & eo, out_a & eo);
         cmp("ibuf_a", ~ed & ~lcd_a, ib_a);
         cmp("ibuf_b", ~dr & ~lcd_b, ib_b);
         cmp("irq_in", {6'h00, en[2] & ~lcd_a[1] & ext_a[1], en[1] & ~lcd_a[0] & ext_a[0]}, {6'h00, nmi_o, irq_o});
         rd(16'h0000);
         cmp("rd_a", (ed & d) | (~ed & ((eo & ev) | (~eo & ext_a))), got);
         cmp("oe_b", dr & ~lcd_b, oe_b);
         cmp("out_b", d & dr & ~lcd_b, out_b & dr & ~lcd_b);
         rd(16'h0001);
         cmp("rd_b", (dr & d) | (~dr & ext_b), got);
      end
   endtask
   initial begin
      {arst_n, wr_stb, rd_stb, addr, wdata, lcd_a, lcd_b, ext_a, ext_b, en} = 0;
      rows[0] = {8'hff, 8'ha5, 8'h00, 4'h0, 8'h00};
      rows[1] = {8'h00, 8'h3c, 8'h00, 4'h0, 8'h96};
      rows[2] = {8'hf0, 8'h0f, 8'h81, 4'h0, 8'h5a};
      rows[3] = {8'h00, 8'h00, 8'h00, 4'hf, 8'h03};
      rows[4] = {8'hff, 8'hff, 8'h0b, 4'he, 8'h00};
      rows[5] = {8'h0f, 8'h55, 8'h00, 4'h1, 8'haa};
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      wr(16'h0002, 8'hff);
      wr(16'h0003, 8'hff);
      rd(16'h0000);
      cmp("rst_a", 8'h00, got);
      rd(16'h0001);
      cmp("rst_b", 8'h00, got);
      for (i = 0; i < 6; i = i + 1) begin
         {lcd_a, en, ext_a} <= rows[i][19:0];
         {lcd_b, ext_b} <= {rows[i][19:12], rows[i][7:0]};
         wr(16'h0002, rows[i][35:28]);
         wr(16'h0000, rows[i][27:20]);
         wr(16'h0003, rows[i][35:28]);
         wr(16'h0001, rows[i][27:20]);
         repeat (4) @(posedge clock);
         check_ports(rows[i][35:28], rows[i][27:20]);
         $display("row %0d done", i);
      end
      // stored data written while lcd owns the low four first-port pins and all second-port pins shows on pin_out once released
      {lcd_a, lcd_b, en} <= 20'h0_ffff;
      wr(16'h0000, 8'h3c);
      wr(16'h0001, 8'hc3);
      {lcd_a, lcd_b} <= 16'h0000;
      repeat (2) @(posedge clock);
      cmp("held_a", 8'h3c, out_a);
      cmp("held_b", 8'hc3, out_b);
      rd(16'h0010);
      cmp("unmapped", 8'h00, got);
      $display("handwritten tests done");
      close_out;
   end
endmodule // tb
